// ---- cscic_chan_model.sv ----
`timescale 1ns/1ps
// ****
// six counter channels behind the control block
// ****
module cscic_chan_model (
    input wire logic       sys_clk_i,
    input wire logic       reset_i,
    input wire logic [5:0] count_clk_i,
    input wire logic [5:0] gate_i,
    input wire logic [5:0] fire_i,
    output logic     [5:0] out_o,
    output logic     [5:0] event_o
);
    logic [5:0] clk_q;
    // output toggles on each gated count edge
    always_ff @(posedge sys_clk_i) begin
        clk_q <= count_clk_i;
        if (reset_i) out_o <= 6'h00;
        else out_o <= out_o ^ (count_clk_i & ~clk_q & gate_i);
    end
    // interrupt condition raised on command of the bench
    always_ff @(posedge sys_clk_i) begin
        event_o <= reset_i ? 6'h00 : fire_i;
    end
endmodule // cscic_chan_model

// ---- cscic_chk.sv ----
`timescale 1ns/1ps
// ****
// port checker
// ****
module cscic_chk #(
    parameter logic [15:0] ID_CODE = 16'h0000
) (
    input wire logic        sys_clk_i,
    input wire logic        reset_i,
    input wire logic [7:0]  addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic        write_i,
    input wire logic        read_i,
    input wire logic [15:0] rdata_o,
    input wire logic [5:0]  channel_out_i,
    input wire logic [3:0]  prog_clk_i,
    input wire logic [15:0] general_port_two_i,
    input wire logic [5:0]  count_clk_o,
    input wire logic [5:0]  gate_o,
    input wire logic        irq_o
);
    logic [8:0]  sel0;
    logic [5:0]  ena;
    logic        settled;
    logic [5:0]  out_d;
    logic [3:0]  prog_d;
    logic [15:0] pin_d1;
    logic [15:0] pin_d2;
    logic [15:0] pin_d3;
    // shadow of channel 0 select and the enables
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            sel0 <= 9'h000;
            ena <= 6'h00;
            settled <= 1'b0;
        end else begin
            settled <= !(write_i && addr_i == 8'h08);
            if (write_i && addr_i == 8'h08) sel0 <= {wdata_i[12:8], wdata_i[3:0]};
            if (write_i && addr_i == 8'h04) ena <= wdata_i[5:0];
        end
    end
    // delay lines matching route latency
    always_ff @(posedge sys_clk_i) begin
        out_d <= channel_out_i;
        prog_d <= prog_clk_i;
        pin_d1 <= general_port_two_i;
        pin_d2 <= pin_d1;
        pin_d3 <= pin_d2;
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    chk_id_fixed: assert property (read_i && addr_i == 8'h00 |=> rdata_o == ID_CODE)
        else $error("identity read wrong");
    chk_resv_zero: assert property (read_i && addr_i == 8'h04 |=> rdata_o[15:14] == 2'h0 && rdata_o[7:6] == 2'h0)
        else $error("reserved event bits set");
    chk_enable_read: assert property (read_i && addr_i == 8'h04 |=> rdata_o[5:0] == ena)
        else $error("enable readback wrong");
    chk_select_read: assert property (read_i && addr_i == 8'h08 |=> rdata_o == {3'h0, sel0[8:4], 4'h0, sel0[3:0]})
        else $error("select readback wrong");
    chk_gate_const: assert property (settled && sel0[8:5] == 4'h0 |-> gate_o[0] == sel0[4])
        else $error("constant gate wrong");
    chk_clk_chan: assert property (settled && sel0[3:0] inside {[4'h2:4'h7]} |-> count_clk_o[0] == out_d[sel0[3:0] - 4'h2])
        else $error("channel clock route wrong");
    chk_clk_prog: assert property (settled && sel0[3:2] == 2'b10 |-> count_clk_o[0] == prog_d[sel0[1:0]])
        else $error("programmable clock route wrong");
    chk_gate_port: assert property (settled && sel0[8] |-> gate_o[0] == pin_d3[sel0[7:4]])
        else $error("port gate route wrong");
    chk_irq_masked: assert property (ena == 6'h00 && $past(ena) == 6'h00 |-> !irq_o)
        else $error("masked interrupt raised");
    chk_irq_cause: assert property ($rose(irq_o) |-> $past(ena) != 6'h00)
        else $error("interrupt without enable");
endmodule // cscic_chk

bind cscic_top cscic_chk #(.ID_CODE(ID_CODE)) u_chk (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o), .channel_out_i(channel_out_i),
    .prog_clk_i(prog_clk_i), .general_port_two_i(general_port_two_i),
    .count_clk_o(count_clk_o), .gate_o(gate_o), .irq_o(irq_o)
);

// ---- cscic_map.svh ----
`ifndef CSCIC_MAP_SVH
`define CSCIC_MAP_SVH

// ************************************************************
// register offsets (word index = byte address / 4)
// ************************************************************
`define CSCIC_OFF_IDENTITY   8'h00
`define CSCIC_OFF_EVENTS     8'h04
`define CSCIC_OFF_SELECT0    8'h08
`define CSCIC_SELECT_STRIDE  8'h04

// ************************************************************
// field positions
// ************************************************************
`define CSCIC_FLAG_LSB       8
`define CSCIC_FLAG_MSB       13
`define CSCIC_ENA_LSB        0
`define CSCIC_ENA_MSB        5
`define CSCIC_GATE_LSB       8
`define CSCIC_GATE_MSB       12
`define CSCIC_CLK_LSB        0
`define CSCIC_CLK_MSB        3

// ************************************************************
// reset values and identity
// ************************************************************
`define CSCIC_ID_VALUE       16'h5a3c
`define CSCIC_RESET_FIELD    16'h0000

// ************************************************************
// source codes
// ************************************************************
`define CSCIC_CLK_REF        4'h0
`define CSCIC_CLK_RSVD       4'h1
`define CSCIC_CODE_CH_FIRST  4'h2
`define CSCIC_CODE_PCLK_FIRST 4'h8
`define CSCIC_CODE_HS1       4'hc
`define CSCIC_CODE_HS2       4'hd
`define CSCIC_CODE_HS1_N     4'he
`define CSCIC_CODE_HS2_N     4'hf
`define CSCIC_GATE_LOW       5'h00
`define CSCIC_GATE_HIGH      5'h01

// ************************************************************
// timing
// ************************************************************
`define CSCIC_SYS_HZ         125000000
`define CSCIC_REF_HZ         5000000
`define CSCIC_REF_DIV        (`CSCIC_SYS_HZ / `CSCIC_REF_HZ)

`endif

// ---- cscic_pkg.sv ----
package cscic_pkg;

    // ************************************************************
    // shared types
    // ************************************************************
    localparam int NUM_CH = 6;

    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [15:0] wdata;
    } cscic_bus_req_t;

    // per-channel routing selection
    typedef struct packed {
        logic [4:0] gate_sel;
        logic [3:0] clk_sel;
    } cscic_select_t;

    // shared source pool seen by every channel
    typedef struct packed {
        logic        ref_clk;
        logic [5:0]  ch_out;
        logic [3:0]  prog_clk;
        logic        hs_one;
        logic        hs_two;
        logic [15:0] port_two;
    } cscic_pool_t;

    typedef enum logic [1:0] {
        CSCIC_IDLE,
        CSCIC_READ
    } cscic_bus_state_t;

endpackage

// ---- cscic_ref_div.sv ----
`timescale 1ns/1ps
`include "cscic_map.svh"

module cscic_ref_div #(
    parameter int DIV = `CSCIC_REF_DIV
) (
    input  wire logic sys_clk_i,
    input  wire logic reset_i,
    output logic      ref_o
);
    localparam int HALF = DIV / 2;

    logic [7:0] cnt;

    // square wave near 5 MHz from the system clock
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cnt   <= 8'h00;
            ref_o <= 1'b0;
        end else if (cnt == 8'(DIV - 1)) begin
            cnt   <= 8'h00;
            ref_o <= 1'b0;
        end else begin
            cnt   <= cnt + 8'h01;
            if (cnt == 8'(HALF - 1)) begin
                ref_o <= 1'b1;
            end
        end
    end

endmodule // cscic_ref_div

// ---- cscic_route_mux.sv ----
`timescale 1ns/1ps
`include "cscic_map.svh"

module cscic_route_mux (
    input  wire logic                  sys_clk_i,
    input  wire logic                  reset_i,
    input  wire cscic_pkg::cscic_select_t sel_i,
    input  wire cscic_pkg::cscic_pool_t   pool_i,
    output logic                       count_clk_o,
    output logic                       gate_o
);
    import cscic_pkg::*;

    // shared 14-entry source decode for clock and gate codes 2..15
    function automatic logic pick_common(input logic [3:0] code, input cscic_pool_t p);
        logic r;
        r = 1'b0;
        case (code)
            4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: r = p.ch_out[3'(code - `CSCIC_CODE_CH_FIRST)];
            4'h8, 4'h9, 4'ha, 4'hb: r = p.prog_clk[2'(code - `CSCIC_CODE_PCLK_FIRST)];
            `CSCIC_CODE_HS1:   r = p.hs_one;
            `CSCIC_CODE_HS2:   r = p.hs_two;
            `CSCIC_CODE_HS1_N: r = ~p.hs_one;
            `CSCIC_CODE_HS2_N: r = ~p.hs_two;
            default:           r = 1'b0;
        endcase
        return r;
    endfunction

    // registered clock pick; own output allowed as source
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            count_clk_o <= 1'b0;
        end else if (sel_i.clk_sel == `CSCIC_CLK_REF) begin
            count_clk_o <= pool_i.ref_clk;
        end else if (sel_i.clk_sel == `CSCIC_CLK_RSVD) begin
            count_clk_o <= 1'b0; // reserved code idles low
        end else begin
            count_clk_o <= pick_common(sel_i.clk_sel, pool_i);
        end
    end

    // registered gate pick
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            gate_o <= 1'b0;
        end else if (sel_i.gate_sel[4]) begin
            gate_o <= pool_i.port_two[sel_i.gate_sel[3:0]];
        end else if (sel_i.gate_sel == `CSCIC_GATE_LOW) begin
            gate_o <= 1'b0;
        end else if (sel_i.gate_sel == `CSCIC_GATE_HIGH) begin
            gate_o <= 1'b1;
        end else begin
            gate_o <= pick_common(sel_i.gate_sel[3:0], pool_i);
        end
    end

endmodule // cscic_route_mux

// ---- cscic_top.sv ----
`timescale 1ns/1ps
`include "cscic_map.svh"

module cscic_top #(
    parameter logic [15:0] ID_CODE = `CSCIC_ID_VALUE // arbitrary value
) (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        write_i,
    input  wire logic        read_i,
    output logic      [15:0] rdata_o,
    input  wire logic [5:0]  channel_out_i,
    input  wire logic [5:0]  channel_event_i,
    input  wire logic [3:0]  prog_clk_i,
    input  wire logic        handshake_line_one_i,
    input  wire logic        handshake_line_two_i,
    input  wire logic [15:0] general_port_two_i,
    output logic      [5:0]  count_clk_o,
    output logic      [5:0]  gate_o,
    output logic             irq_o
);
    import cscic_pkg::*;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [17:0] pin_meta;
    logic [17:0] pin_sync;

    // two flops on strobes and port pins
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pin_meta <= 18'h00000;
            pin_sync <= 18'h00000;
        end else begin
            pin_meta <= {handshake_line_two_i, handshake_line_one_i, general_port_two_i};
            pin_sync <= pin_meta;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    logic [5:0]    event_flags;
    logic [5:0]    event_enables;
    cscic_select_t select_reg [NUM_CH];
    logic [5:0]    event_prev;
    logic          ref_clk;
    cscic_pool_t   pool;

    // decode a channel select offset, returns channel or 7 if none
    function automatic logic [2:0] sel_index(input logic [7:0] a);
        logic [2:0] r;
        r = 3'h7;
        for (int k = 0; k < NUM_CH; k++) begin
            if (a == 8'(`CSCIC_OFF_SELECT0 + k * `CSCIC_SELECT_STRIDE)) begin
                r = 3'(k);
            end
        end
        return r;
    endfunction

    wire logic events_wr = write_i && (addr_i == `CSCIC_OFF_EVENTS);
    wire logic [2:0] wr_ch = sel_index(addr_i);
    wire logic [5:0] event_rise = channel_event_i & ~event_prev;

    // edge detect of counter interrupt conditions
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            event_prev <= 6'h00;
        end else begin
            event_prev <= channel_event_i;
        end
    end

    // sticky flags, set wins over clear, bit k is channel k
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            event_flags <= 6'h00;
        end else begin
            event_flags <= (event_flags
                & ~(events_wr ? wdata_i[`CSCIC_FLAG_MSB:`CSCIC_FLAG_LSB] : 6'h00))
                | event_rise;
        end
    end

    // enables, written as a group
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            event_enables <= 6'h00;
        end else if (events_wr) begin
            event_enables <= wdata_i[`CSCIC_ENA_MSB:`CSCIC_ENA_LSB];
        end
    end

    // per-channel select registers, reserved bits dropped
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            for (int k = 0; k < NUM_CH; k++) begin
                select_reg[k] <= '0;
            end
        end else if (write_i && wr_ch != 3'h7) begin
            select_reg[wr_ch].gate_sel <= wdata_i[`CSCIC_GATE_MSB:`CSCIC_GATE_LSB];
            select_reg[wr_ch].clk_sel  <= wdata_i[`CSCIC_CLK_MSB:`CSCIC_CLK_LSB];
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    logic [15:0] next_rdata;
    logic [2:0]  rd_ch;

    // read mux, unmapped and reserved bits give zero
    always_comb begin
        rd_ch      = sel_index(addr_i);
        next_rdata = 16'h0000;
        if (addr_i == `CSCIC_OFF_IDENTITY) begin
            next_rdata = ID_CODE;
        end else if (addr_i == `CSCIC_OFF_EVENTS) begin
            next_rdata[`CSCIC_FLAG_MSB:`CSCIC_FLAG_LSB] = event_flags;
            next_rdata[`CSCIC_ENA_MSB:`CSCIC_ENA_LSB]   = event_enables;
        end else if (rd_ch != 3'h7) begin
            next_rdata[`CSCIC_GATE_MSB:`CSCIC_GATE_LSB] = select_reg[rd_ch].gate_sel;
            next_rdata[`CSCIC_CLK_MSB:`CSCIC_CLK_LSB]   = select_reg[rd_ch].clk_sel;
        end
    end

    // read data valid only the cycle after the strobe
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rdata_o <= 16'h0000;
        end else if (read_i) begin
            rdata_o <= next_rdata;
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // ************************************************************
    // interrupt output
    // ************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(event_flags & event_enables);
        end
    end

    // ************************************************************
    // routing
    // ************************************************************
    cscic_ref_div u_ref (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .ref_o     (ref_clk)
    );

    // shared source pool; channel outputs include each channel's own
    always_comb begin
        pool.ref_clk  = ref_clk;
        pool.ch_out   = channel_out_i;
        pool.prog_clk = prog_clk_i;
        pool.hs_one   = pin_sync[16];
        pool.hs_two   = pin_sync[17];
        pool.port_two = pin_sync[15:0];
    end

    // one router per channel, no rate check on chosen clock
    for (genvar g = 0; g < NUM_CH; g++) begin : g_route
        cscic_route_mux u_mux (
            .sys_clk_i   (sys_clk_i),
            .reset_i     (reset_i),
            .sel_i       (select_reg[g]),
            .pool_i      (pool),
            .count_clk_o (count_clk_o[g]),
            .gate_o      (gate_o[g])
        );
    end

endmodule // cscic_top

// ---- cscic_top_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module cscic_top_tb_top;
    localparam logic [15:0] ID = 16'h2b6e; // arbitrary value
    logic        sys_clk, reset, write, read, hs_one, hs_two, irq;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata, port;
    logic [5:0]  ch_out, ch_ev, cclk, gate, fire;
    logic [3:0]  prog;
    int          n_errors = 0;
    int          cmp_count = 0;
    cscic_top #(.ID_CODE(ID)) uut (
        .sys_clk_i(sys_clk), .reset_i(reset), .addr_i(addr), .wdata_i(wdata), .write_i(write),
        .read_i(read), .rdata_o(rdata), .channel_out_i(ch_out), .channel_event_i(ch_ev),
        .prog_clk_i(prog), .handshake_line_one_i(hs_one), .handshake_line_two_i(hs_two),
        .general_port_two_i(port), .count_clk_o(cclk), .gate_o(gate), .irq_o(irq)
    );
    cscic_chan_model u_chan (
        .sys_clk_i(sys_clk), .reset_i(reset), .count_clk_i(cclk), .gate_i(gate),
        .fire_i(fire), .out_o(ch_out), .event_o(ch_ev)
    );
    // ****
    // bus cycles
    // ****
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        write <= 1'b1;
        @(posedge sys_clk);
        write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        addr <= a;
        read <= 1'b1;
        @(posedge sys_clk);
        read <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge sys_clk);
        fire <= m;
        @(posedge sys_clk);
        fire <= 6'h00;
        repeat (3) @(posedge sys_clk);
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_reset;
        rd(8'h00, ID);
        rd(8'h04, 16'h0000);
        for (int k = 0; k < 6; k++) rd(8'h08 + 8'(4 * k), 16'h0000);
        rd(8'h40, 16'h0000);
        wr(8'h00, 16'hffff);
        rd(8'h00, ID);
    endtask
    task automatic t_select;
        // channels end on the 5 MHz reference, gate high
        for (int k = 0; k < 6; k++) begin
            wr(8'h08 + 8'(4 * k), 16'hffff);
            rd(8'h08 + 8'(4 * k), 16'h1f0f);
            wr(8'h08 + 8'(4 * k), 16'h0100);
        end
    endtask
    task automatic t_events;
        wr(8'h04, 16'h003f);
        for (int k = 0; k < 6; k++) begin
            pulse(6'h01 << k);
            rd(8'h04, 16'h003f | (16'h0100 << k));
            `CHK(irq, 1'b1)
            wr(8'h04, 16'h003f | (16'h0100 << k));
            rd(8'h04, 16'h003f);
        end
        pulse(6'h03);
        wr(8'h04, 16'h0100);
        rd(8'h04, 16'h0200);
        `CHK(irq, 1'b0)
        wr(8'h04, 16'h0002);
        rd(8'h04, 16'h0202);
        `CHK(irq, 1'b1)
        wr(8'h04, 16'hffc0);
        rd(8'h04, 16'h0000);
    endtask
    task automatic t_route;
        // channel 0 may take its own output
        for (int c = 2; c < 16; c++) begin
            wr(8'h08, 16'(c * 257));
            repeat (4) @(posedge sys_clk);
            repeat (40) begin
                @(posedge sys_clk);
                #1 `CHK(gate[0], cclk[0])
            end
        end
        for (int c = 8; c < 16; c++) begin
            wr(8'h08, 16'(c * 257));
            for (int v = 0; v < 2; v++) begin
                @(posedge sys_clk);
                prog <= v[0] ? 4'h1 << (c - 8) : ~(4'h1 << (c - 8));
                hs_one <= (c == 12) ? v[0] : !v[0];
                hs_two <= (c == 13) ? v[0] : !v[0];
                repeat (5) @(posedge sys_clk);
                #1 `CHK(cclk[0], v[0])
                `CHK(gate[0], v[0])
            end
        end
        for (int p = 0; p < 16; p += 15) begin
            wr(8'h08, 16'h1000 + 16'(p << 8));
            port <= 16'h0001 << p;
            repeat (5) @(posedge sys_clk);
            #1 `CHK(gate[0], 1'b1)
            port <= ~(16'h0001 << p);
            repeat (5) @(posedge sys_clk);
            #1 `CHK(gate[0], 1'b0)
        end
    endtask
    task automatic conclude;
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // main sequence, with a second reset in mid-run
    initial begin
        {reset, write, read, hs_one, hs_two} = 5'h10;
        {addr, wdata, port, prog, fire} = '0;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset;
        t_select;
        t_events;
        t_route;
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset;
        conclude;
    end
    // watchdog
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_errors++;
        conclude;
    end
endmodule // cscic_top_tb_top
